//--- core/wt_pkg.sv
package wt_pkg;

  // Clock rates; the watchdog oscillator is modelled as a one-cycle tick enable.
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned WT_OSC_HZ      = 10_000;
  localparam int unsigned TICK_DIV       = CLK_HZ / WT_OSC_HZ;
  localparam logic [9:0]  TICK_LAST      = 10'(TICK_DIV - 1);

  // Reset hold lengths in system clock cycles.
  localparam int unsigned HOLD_IPO_CYC   = 66;
  localparam int unsigned HOLD_XTAL_CYC  = 5000;

  // Register byte addresses.
  localparam logic [11:0] CTRL_OFF       = 12'hFF0;
  localparam logic [11:0] RLD_UPPER_OFF  = 12'hFF4;
  localparam logic [11:0] RLD_HIGH_OFF   = 12'hFF8;
  localparam logic [11:0] RLD_LOW_OFF    = 12'hFFC;
  localparam logic [11:0] IRQ_STAT_OFF   = 12'hFE0;
  localparam logic [11:0] IRQ_CLR_OFF    = 12'hFE4;
  localparam logic [11:0] IRQ_EN_OFF     = 12'hFE8;

  // Unlock sequence bytes.
  localparam logic [7:0]  UNLOCK_FIRST   = 8'h55;
  localparam logic [7:0]  UNLOCK_SECOND  = 8'hAA;

  // Reload and refresh figures.
  localparam logic [23:0] RELOAD_RST     = 24'h000400;
  localparam logic [23:0] REFRESH_FLOOR  = 24'h000002;
  localparam logic [23:0] CNT_TERMINAL   = 24'h000001;

  // Interrupt status bits.
  localparam int unsigned IRQ_W          = 2;
  localparam int unsigned IRQ_TIMEOUT    = 0;
  localparam int unsigned IRQ_LATE       = 1;

  // Reset status bits, read at the control address.
  localparam int unsigned RSTAT_W        = 4;
  localparam int unsigned RSTAT_WD       = 0;
  localparam int unsigned RSTAT_STOP     = 1;
  localparam int unsigned RSTAT_EXT      = 2;
  localparam int unsigned RSTAT_POR      = 3;
  localparam logic [3:0]  RSTAT_RST      = 4'h8;

  // Reset vector addresses.
  localparam logic [15:0] VEC_LO_ADDR    = 16'h0002;
  localparam logic [15:0] VEC_HI_ADDR    = 16'h0003;

  // Flash option bits as loaded during reset.
  typedef struct packed {
    logic always_on_option_bit;
    logic int_mode;
    logic xtal_en;
  } wt_opt_s;

  typedef enum logic {WT_OFF, WT_ON} wt_state_e;

endpackage

//--- core/wt_rst_hold.sv
`timescale 1ns/100ps
module wt_rst_hold
  import wt_pkg::*;
#(
  parameter int unsigned XTAL_HOLD_CYC = HOLD_XTAL_CYC
)(
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Reset requests and conditions.
  input  wire logic restart,
  input  wire logic xtal_en,
  input  wire logic ext_rst_n,
  // Hold state.
  output logic      hold_q,
  output logic      done_q
);

  logic [12:0] cnt_q;
  logic [12:0] limit_w;
  logic        at_limit_w;

  // Crystal start-up needs the long hold.
  assign limit_w    = xtal_en ? 13'(XTAL_HOLD_CYC - 1) : 13'(HOLD_IPO_CYC - 1);
  assign at_limit_w = (cnt_q >= limit_w);

  ////////////////////////////////////////////////////////////////////////////
  // Hold counter; a pin still asserted at the end keeps the device in reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_q <= 1'b1;
      cnt_q  <= 13'h0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (restart)
      begin
        hold_q <= 1'b1;
        cnt_q  <= 13'h0;
      end
      else if (hold_q)
      begin
        if (!at_limit_w)
          cnt_q <= cnt_q + 13'h1;
        else if (ext_rst_n)
        begin
          hold_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_min_a: assert property (restart |=> hold_q [*8])
    else $error("Hold ended too early after a reset request.");
  hold_end_a: assert property ($fell(hold_q) |-> $past(cnt_q) == $past(limit_w))
    else $error("Hold released at the wrong count.");
  pin_wait_a: assert property (hold_q && !ext_rst_n && !restart |=> hold_q)
    else $error("Hold released while the reset pin was asserted.");

endmodule

//--- core/wt_top.sv
`timescale 1ns/100ps
module wt_top
  import wt_pkg::*;
#(
  parameter int unsigned XTAL_HOLD_CYC = HOLD_XTAL_CYC
)(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Option bits, reset pin and core events.
  input  wire wt_opt_s     opt_pins,
  input  wire logic        ext_rst_n,
  input  wire logic        stop_recover,
  input  wire logic        refresh_instruction,
  // System outputs.
  output logic             sys_rst,
  output logic             irq,
  output logic             vec_fetch,
  output logic      [15:0] vec_addr
);

  wt_state_e    state_q, state_d;
  logic [9:0]   div_q;
  logic         tick_q;
  logic [23:0]  cnt_q;
  logic [7:0]   rld_upper_q, rld_high_q, rld_low_q;
  logic         unl_step_q, unlocked_q;
  wt_opt_s      opt_q;
  logic [3:0]   rstat_q;
  logic [1:0]   irq_st_q, irq_en_q;
  logic [1:0]   vec_step_q;
  logic         hold_w, done_w;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; writes are ignored while the processor is held in reset.
  logic        setup_w, wr_w, hit_w;
  logic        wr_ctrl_w, wr_u_w, wr_h_w, wr_l_w, wr_clr_w, wr_en_w;
  logic [31:0] rd_w;
  assign setup_w   = psel && !penable;
  assign wr_w      = psel && penable && pready && pwrite && !hold_w;
  assign hit_w     = (paddr == CTRL_OFF) || (paddr == RLD_UPPER_OFF) ||
                     (paddr == RLD_HIGH_OFF) || (paddr == RLD_LOW_OFF) ||
                     (paddr == IRQ_STAT_OFF) || (paddr == IRQ_CLR_OFF) ||
                     (paddr == IRQ_EN_OFF);
  assign wr_ctrl_w = wr_w && (paddr == CTRL_OFF);
  assign wr_u_w    = wr_w && unlocked_q && (paddr == RLD_UPPER_OFF);
  assign wr_h_w    = wr_w && unlocked_q && (paddr == RLD_HIGH_OFF);
  assign wr_l_w    = wr_w && unlocked_q && (paddr == RLD_LOW_OFF);
  assign wr_clr_w  = wr_w && (paddr == IRQ_CLR_OFF);
  assign wr_en_w   = wr_w && (paddr == IRQ_EN_OFF);
  // The control address reads back reset status; the clear register reads zero.
  assign rd_w = (paddr == CTRL_OFF)      ? {28'h0, rstat_q} :
                (paddr == RLD_UPPER_OFF) ? {24'h0, rld_upper_q} :
                (paddr == RLD_HIGH_OFF)  ? {24'h0, rld_high_q} :
                (paddr == RLD_LOW_OFF)   ? {24'h0, rld_low_q} :
                (paddr == IRQ_STAT_OFF)  ? {30'h0, irq_st_q} :
                (paddr == IRQ_EN_OFF)    ? {30'h0, irq_en_q} : 32'h0;

  // One wait-free access phase: answer is prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= setup_w;
      pslverr <= setup_w && !hit_w;
      prdata  <= (setup_w && !pwrite) ? rd_w : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog oscillator tick; runs from power-up regardless of the hold.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q  <= 10'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= (div_q == TICK_LAST) ? 10'h0 : div_q + 10'h1;
      tick_q <= (div_q == TICK_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter events.
  logic [23:0] reload_w;
  logic        refresh_ok_w, refresh_late_w, timeout_w, wd_rst_w, ao_start_w;
  assign reload_w       = {rld_upper_q, rld_high_q, rld_low_q};
  assign refresh_ok_w   = refresh_instruction && !hold_w &&
                          ((state_q == WT_OFF) || (cnt_q > REFRESH_FLOOR));
  assign refresh_late_w = refresh_instruction && !hold_w &&
                          (state_q == WT_ON) && (cnt_q <= REFRESH_FLOOR);
  // Terminal count at one, so a reload of N ticks takes N oscillator periods.
  assign timeout_w      = (state_q == WT_ON) && tick_q && (cnt_q == CNT_TERMINAL);
  assign wd_rst_w       = timeout_w && !opt_q.int_mode;
  assign ao_start_w     = done_w && opt_q.always_on_option_bit;

  // On/off state: power-on and watchdog resets turn it off unless the option bit restarts it; stop recovery does not.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      WT_OFF:  if (refresh_ok_w || ao_start_w) state_d = WT_ON;
      WT_ON:   if (wd_rst_w && !opt_q.always_on_option_bit) state_d = WT_OFF;
      default: state_d = WT_OFF;
    endcase
  end

  // Down-counter; an ignored late refresh lets the time-out go ahead.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= WT_OFF;
      cnt_q   <= RELOAD_RST;
    end
    else
    begin
      state_q <= state_d;
      if (wd_rst_w)
        cnt_q <= RELOAD_RST;
      else if (refresh_ok_w || timeout_w || ao_start_w)
        cnt_q <= reload_w;
      else if (state_q == WT_ON && tick_q)
        cnt_q <= cnt_q - 24'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reload bytes; a watchdog system reset restores the default period.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rld_upper_q <= RELOAD_RST[23:16];
      rld_high_q  <= RELOAD_RST[15:8];
      rld_low_q   <= RELOAD_RST[7:0];
    end
    else if (wd_rst_w)
    begin
      rld_upper_q <= RELOAD_RST[23:16];
      rld_high_q  <= RELOAD_RST[15:8];
      rld_low_q   <= RELOAD_RST[7:0];
    end
    else
    begin
      if (wr_u_w) rld_upper_q <= pwdata[7:0];
      if (wr_h_w) rld_high_q  <= pwdata[7:0];
      if (wr_l_w) rld_low_q   <= pwdata[7:0];
    end
  end

  // Unlock tracker; writing the low byte relocks, guarding against runaway writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unl_step_q <= 1'b0;
      unlocked_q <= 1'b0;
    end
    else if (stop_recover || wd_rst_w || wr_l_w)
    begin
      unl_step_q <= 1'b0;
      unlocked_q <= 1'b0;
    end
    else if (wr_ctrl_w)
    begin
      unl_step_q <= (pwdata[7:0] == UNLOCK_FIRST);
      unlocked_q <= unl_step_q && (pwdata[7:0] == UNLOCK_SECOND);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option bits are sampled throughout the hold and settle before release.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      opt_q <= '0;
    else if (hold_w)
      opt_q <= opt_pins;
  end

  // Reset status: the latest cause is recorded, the pin flag is added in hold.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rstat_q <= RSTAT_RST;
    else if (wd_rst_w)
      rstat_q <= 4'h1 << RSTAT_WD;
    else if (stop_recover)
      rstat_q <= 4'h1 << RSTAT_STOP;
    else if (hold_w && !ext_rst_n)
      rstat_q[RSTAT_EXT] <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset hold sequencer; both watchdog reset and stop recovery restart it.
  wt_rst_hold #(
    .XTAL_HOLD_CYC (XTAL_HOLD_CYC)
  ) u_hold (
    .pclk      (pclk),
    .presetn   (presetn),
    .restart   (wd_rst_w || stop_recover),
    .xtal_en   (opt_q.xtal_en),
    .ext_rst_n (ext_rst_n),
    .hold_q    (hold_w),
    .done_q    (done_w)
  );

  // System outputs registered so the core sees clean levels.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sys_rst <= 1'b1;
    else
      sys_rst <= hold_w || wd_rst_w || stop_recover;
  end

  // Reset vector fetch: low address byte then high, one cycle each.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vec_step_q <= 2'h0;
      vec_fetch  <= 1'b0;
      vec_addr   <= VEC_LO_ADDR;
    end
    else
    begin
      vec_step_q <= done_w ? 2'h2 : (vec_step_q != 2'h0 ? vec_step_q - 2'h1 : 2'h0);
      vec_fetch  <= done_w || (vec_step_q == 2'h2);
      vec_addr   <= (vec_step_q == 2'h2) ? VEC_HI_ADDR : VEC_LO_ADDR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over a clear in the same cycle.
  logic [1:0] irq_set_w;
  assign irq_set_w = {refresh_late_w, timeout_w && opt_q.int_mode};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_st_q <= 2'h0;
      irq_en_q <= 2'h0;
      irq      <= 1'b0;
    end
    else
    begin
      irq_st_q <= (irq_st_q & ~(wr_clr_w ? pwdata[1:0] : 2'h0)) | irq_set_w;
      if (wr_en_w) irq_en_q <= pwdata[1:0];
      irq      <= |(irq_st_q & irq_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence late_refresh_s;
    refresh_late_w && !tick_q;
  endsequence
  sequence cnt_frozen_s;
    cnt_q == $past(cnt_q);
  endsequence

  tick_space_a:   assert property (tick_q |=> (!tick_q) [*8])
    else $error("Oscillator ticks too close together.");
  tick_div_a:     assert property (tick_q |-> $past(div_q) == TICK_LAST)
    else $error("Oscillator tick at the wrong divider count.");
  on_stays_a:     assert property (state_q == WT_ON && !wd_rst_w |=> state_q == WT_ON)
    else $error("Watchdog turned off without a reset.");
  ao_start_a:     assert property (ao_start_w |=> state_q == WT_ON && cnt_q == $past(reload_w))
    else $error("Always-on option did not start the counter.");
  reload_cat_a:   assert property (refresh_ok_w |=> cnt_q == $past(reload_w))
    else $error("Refresh did not load the reload value.");
  count_down_a:   assert property (state_q == WT_ON && tick_q && !timeout_w && !refresh_ok_w
                                   |=> cnt_q == $past(cnt_q) - 24'h1)
    else $error("Counter did not step down on a tick.");
  late_ignore_a:  assert property (late_refresh_s |=> cnt_frozen_s)
    else $error("Late refresh changed the counter.");
  rst_default_a:  assert property (wd_rst_w |=> reload_w == RELOAD_RST && sys_rst)
    else $error("Watchdog reset did not restore default reload.");
  irq_mode_a:     assert property (timeout_w && opt_q.int_mode |=> irq_st_q[IRQ_TIMEOUT]
                                   && (!sys_rst || $past(hold_w || stop_recover)))
    else $error("Interrupt-mode time-out did not set its flag.");
  unlock_keep_a:  assert property (wr_ctrl_w && !wd_rst_w |=> reload_w == $past(reload_w))
    else $error("Control write altered the reload bytes.");
  locked_a:       assert property (wr_w && !unlocked_q && !wd_rst_w
                                   |=> reload_w == $past(reload_w))
    else $error("Locked reload byte was modified.");
  rd_status_a:    assert property (setup_w && !pwrite && paddr == CTRL_OFF
                                   |=> prdata == {28'h0, $past(rstat_q)})
    else $error("Control address did not read reset status.");
  vec_order_a:    assert property (done_w |=> vec_fetch && vec_addr == VEC_LO_ADDR
                                   ##1 vec_fetch && vec_addr == VEC_HI_ADDR)
    else $error("Reset vector fetch out of order.");
  hold_run_a:     assert property (hold_w && state_q == WT_ON && tick_q && cnt_q != CNT_TERMINAL
                                   |=> cnt_q == $past(cnt_q) - 24'h1)
    else $error("Counter stalled while the device was held in reset.");
  late_flag_a:    assert property (refresh_late_w |=> irq_st_q[IRQ_LATE])
    else $error("Late refresh did not set its flag.");
  irq_level_a:    assert property ((|(irq_st_q & irq_en_q)) |=> irq)
    else $error("Enabled status bit did not raise the interrupt.");
  vec_idle_a:     assert property (!vec_fetch |-> vec_addr == VEC_LO_ADDR)
    else $error("Vector address left off the low byte when idle.");

endmodule

//--- bench/wt_core_model.sv
`timescale 1ns/100ps
// Processor-side partner: drives the APB master signals and refresh pulses.
module wt_core_model
  import wt_pkg::*;
(
  // Clock.
  input  wire logic        pclk,
  // APB master side.
  output logic      [11:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Refresh instruction pulse.
  output logic             refresh_instruction
);
  // Idle bus at time zero.
  initial
  begin
    paddr               = 12'h000;
    psel                = 1'b0;
    penable             = 1'b0;
    pwrite              = 1'b0;
    pwdata              = 32'h0;
    refresh_instruction = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One APB transfer; it waits for pready and spends one idle edge afterwards,
  // so that a following call never drives psel twice in one time step.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask

  // One refresh instruction, a single-cycle pulse.
  task automatic refresh;
    refresh_instruction <= 1'b1;
    @(posedge pclk);
    refresh_instruction <= 1'b0;
  endtask

  // Unlock, then program all three reload bytes; the low byte relocks.
  task automatic set_reload(input logic [23:0] v);
    logic [31:0] rd;
    logic        err;
    if (v < 24'h000004)
      v = 24'h000004;
    xfer(1'b1, CTRL_OFF, {24'h0, UNLOCK_FIRST}, rd, err);
    xfer(1'b1, CTRL_OFF, {24'h0, UNLOCK_SECOND}, rd, err);
    xfer(1'b1, RLD_UPPER_OFF, {24'h0, v[23:16]}, rd, err);
    xfer(1'b1, RLD_HIGH_OFF, {24'h0, v[15:8]}, rd, err);
    xfer(1'b1, RLD_LOW_OFF, {24'h0, v[7:0]}, rd, err);
  endtask
endmodule

//--- bench/watchdog_timer_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the watchdog block.
module watchdog_timer_tb
  import wt_pkg::*;
;
  localparam int unsigned XH = 100;

  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wt_opt_s     opt_pins;
  logic        ext_rst_n;
  logic        stop_recover;
  logic        refresh_instruction;
  logic        sys_rst;
  logic        irq;
  logic        vec_fetch;
  logic [15:0] vec_addr;
  int          num_errors;
  int          comparisons;
  longint      cyc;
  int          m_stat;

  //////////////////////////////////////////////////////////////////////////////
  // Device and processor partner.
  wt_top #(.XTAL_HOLD_CYC(XH)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .opt_pins(opt_pins), .ext_rst_n(ext_rst_n),
    .stop_recover(stop_recover), .refresh_instruction(refresh_instruction),
    .sys_rst(sys_rst), .irq(irq), .vec_fetch(vec_fetch), .vec_addr(vec_addr));
  wt_core_model i_core (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .refresh_instruction(refresh_instruction));

  // Clock at 10 MHz and a free cycle count used to place late refreshes.
  initial
  begin
    pclk = 1'b0;
    cyc = 0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  //////////////////////////////////////////////////////////////////////////////
  // Comparison of values and of measured cycle counts.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    comparisons++;
    if (n < lo || n > hi)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask

  // Bounded wait on irq (0), sys_rst (1) or vec_fetch (2).
  task automatic wait_for(input int w, input logic lvl, output int n);
    n = 0;
    while (((w == 0) ? irq : (w == 1) ? sys_rst : vec_fetch) !== lvl && n < 20000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Full reset with new option bits; the hold length is measured.
  task automatic do_reset(input wt_opt_s o, input int lim);
    int n;
    opt_pins <= o;
    presetn  <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn  <= 1'b1;
    wait_for(1, 1'b0, n);
    chk_rng(n, lim, lim + 3);
    m_stat = 0;
  endtask

  task automatic test_done;
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog against hangs; the tests need under 30000 cycles.
  initial
  begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    test_done();
  end

  // Main sequence.
  initial
  begin
    logic [31:0] d;
    logic        e;
    int          n;
    int          r;
    longint      t;
    num_errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    opt_pins = 3'b010;
    ext_rst_n = 1'b1;
    stop_recover = 1'b0;
    r = $urandom(79);
    r = 4 + ($urandom % 4);
    @(posedge pclk);
    // Interrupt mode, quick hold; reset status and an unmapped address.
    do_reset(3'b010, HOLD_IPO_CYC);
    i_core.xfer(1'b0, CTRL_OFF, 32'h0, d, e);
    chk(d, {28'h0, RSTAT_RST});
    i_core.xfer(1'b0, 12'h100 + 12'(($urandom % 32) * 4), 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    // Program a short period; a locked write after it must not stretch it.
    i_core.set_reload(24'(r));
    i_core.xfer(1'b1, RLD_UPPER_OFF, 32'h01, d, e);
    i_core.xfer(1'b1, IRQ_EN_OFF, 32'h3, d, e);
    i_core.refresh();
    wait_for(0, 1'b1, n);
    t = cyc;
    chk_rng(n, (r - 1) * 1000, r * 1000 + 5);
    m_stat = m_stat | 1;
    i_core.xfer(1'b0, IRQ_STAT_OFF, 32'h0, d, e);
    chk(d, 32'(m_stat));
    // Mask, unmask and clear the interrupt.
    i_core.xfer(1'b1, IRQ_EN_OFF, 32'h0, d, e);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    i_core.xfer(1'b1, IRQ_EN_OFF, 32'h3, d, e);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    i_core.xfer(1'b1, IRQ_CLR_OFF, 32'h3, d, e);
    m_stat = 0;
    // A refresh at count 2 is ignored and the next time-out still comes.
    while (cyc < t + (r - 2) * 1000 + 500)
      @(posedge pclk);
    i_core.refresh();
    while (cyc < t + r * 1000 + 50)
      @(posedge pclk);
    m_stat = 3;
    i_core.xfer(1'b0, IRQ_STAT_OFF, 32'h0, d, e);
    chk(d, 32'(m_stat));
    i_core.xfer(1'b1, IRQ_CLR_OFF, 32'h3, d, e);
    m_stat = 0;
    i_core.xfer(1'b0, IRQ_STAT_OFF, 32'h0, d, e);
    chk(d, 32'(m_stat));
    // Reset mode with the crystal hold.
    do_reset(3'b001, XH);
    i_core.set_reload(24'(r));
    i_core.refresh();
    wait_for(1, 1'b1, n);
    chk_rng(n, (r - 1) * 1000, r * 1000 + 5);
    wait_for(1, 1'b0, n);
    chk_rng(n, XH, XH + 4);
    i_core.xfer(1'b0, CTRL_OFF, 32'h0, d, e);
    chk(d & 32'h1, 32'h1);
    // The watchdog reset restored the default period, so arm a short one and start it.
    // Stop recovery follows with the reset pin held past the hold, then the vector fetch.
    i_core.set_reload(24'(r));
    i_core.refresh();
    t = cyc;
    ext_rst_n    <= 1'b0;
    stop_recover <= 1'b1;
    @(posedge pclk);
    stop_recover <= 1'b0;
    repeat (XH + 100) @(posedge pclk);
    chk({31'h0, sys_rst}, 32'h1);
    ext_rst_n <= 1'b1;
    wait_for(2, 1'b1, n);
    chk_rng(n, 1, 8);
    chk({16'h0, vec_addr}, {16'h0, VEC_LO_ADDR});
    @(posedge pclk);
    chk({16'h0, vec_addr}, {16'h0, VEC_HI_ADDR});
    repeat (2) @(posedge pclk);
    chk({31'h0, sys_rst}, 32'h0);
    i_core.xfer(1'b0, CTRL_OFF, 32'h0, d, e);
    chk(d & 32'h6, 32'h6);
    // Reload and running count survive the stop hold; always-on is set before the watchdog reset, whose hold is measured.
    opt_pins <= 3'b101;
    wait_for(1, 1'b1, n);
    chk_rng(int'(cyc - t), (r - 1) * 1000, r * 1000 + 5);
    wait_for(1, 1'b0, n);
    chk_rng(n, XH, XH + 4);
    test_done();
  end
endmodule
